// ### src/slfr_defines.vh
`ifndef SLFR_DEFINES_VH
`define SLFR_DEFINES_VH

// ==========================================================
// primitive codes on the dword path (abstract ids, 4 bits)
// ==========================================================
`define SLFR_PW          4
`define SLFR_P_NONE      4'h0
`define SLFR_P_SYNC      4'h1
`define SLFR_P_X_RDY     4'h2
`define SLFR_P_R_RDY     4'h3
`define SLFR_P_SOF       4'h4
`define SLFR_P_EOF       4'h5
`define SLFR_P_WTRM      4'h6
`define SLFR_P_R_OK      4'h7
`define SLFR_P_R_ERR     4'h8
`define SLFR_P_R_IP      4'h9
`define SLFR_P_HOLD      4'ha
`define SLFR_P_HOLDA     4'hb
`define SLFR_P_DMAT      4'hc
`define SLFR_P_CRC       4'hd

// ==========================================================
// state codes
// ==========================================================
`define SLFR_SW          4
`define SLFR_S_IDLE      4'h0
`define SLFR_S_SENDCRC   4'h1
`define SLFR_S_SENDEOF   4'h2
`define SLFR_S_WAIT      4'h3
`define SLFR_S_CHKRDY    4'h4
`define SLFR_S_WAITFIFO  4'h5
`define SLFR_S_RCVDATA   4'h6
`define SLFR_S_HOLD      4'h7
`define SLFR_S_SENDHOLD  4'h8
`define SLFR_S_RCVEOF    4'h9
`define SLFR_S_BADEND    4'ha
`define SLFR_S_NOCOMM    4'hb

// ==========================================================
// crc
// ==========================================================
`define SLFR_CRC_INIT    32'h52325032
`define SLFR_CRC_POLY    32'h04c11db7

`endif

// ### src/slfr_fifo.v
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// small receive fifo, back-pressure on s_ready_o
// ==========================================================
module slfr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             mclk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] s_data_i,
    input  wire             s_valid_i,
    output wire             s_ready_o,
    output wire [WIDTH-1:0] m_data_o,
    output wire             m_valid_o,
    input  wire             m_ready_i,
    output wire [AW:0]      level_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    wire            wr = s_valid_i && s_ready_o;
    wire            rd = m_valid_o && m_ready_i;

    assign s_ready_o = (cnt_q != DEPTH[AW:0]);
    assign m_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign m_data_o  = mem[rp_q];
    assign level_o   = cnt_q;

    always @(posedge mclk_i) begin
        if (wr) begin
            mem[wp_q] <= s_data_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (wr) begin
                wp_q <= wp_q + 1'b1;
            end
            if (rd) begin
                rp_q <= rp_q + 1'b1;
            end
            if (wr && !rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (rd && !wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ### src/slfr_link.v
// Overview of operation
// - data done: send frame crc, then eof
// - sync in crc/eof state: error, idle
// - send eof, then wait for result
// - wait state sends wtrm, stays otherwise
// - r_ok while waiting: success, idle
// - r_err or sync while waiting: fail, idle
// - phy not ready outside idle: fail, no-comm error
// - x_rdy: send r_rdy, await sof
// - sof while ready moves to receive
// - unexpected words abort ready/fifo-wait states
// - x_rdy with fifo not empty: send sync
// - fifo wait: x_rdy plus empty fifo leaves
// - received data goes to fifo and crc
// - receiving sends r_ip, or dmat on request
// - low fifo room enters hold state
// - received hold enters hold-acknowledge state
// - received eof enters crc check state
// - received wtrm in receive-data state goes to bad end
// - sync while receiving: abort, idle
// - host pending control frame abandons reception
// - hold state sends hold, still accepts data
// - hold exit on room; hold to acknowledge
// - eof state checks crc, sends r_ip
// - hold-acknowledge sends holda or dmat
`timescale 1ns/100ps
`default_nettype none
`include "slfr_defines.vh"

module slfr_link #(
    parameter DW       = 32,
    parameter HEADROOM = 2
) (
    input  wire          mclk_i,
    input  wire          rst_i,
    input  wire          phy_rdy_i,
    input  wire          rx_is_prim_i,
    input  wire [3:0]    rx_prim_i,
    input  wire [DW-1:0] rx_data_i,
    input  wire          rx_valid_i,
    output reg           tx_is_prim_o,
    output reg  [3:0]    tx_prim_o,
    output reg  [DW-1:0] tx_data_o,
    input  wire          tp_tx_start_i,
    input  wire          tp_tx_done_i,
    input  wire          tp_dmat_req_i,
    input  wire          tp_ctrl_pend_i,
    output reg           tp_tx_ok_o,
    output reg           tp_tx_fail_o,
    output reg           tp_illegal_o,
    output reg           tp_rx_abort_o,
    output reg           tp_nocomm_o,
    output reg           tp_crc_ok_o,
    output reg           tp_crc_bad_o,
    output reg  [3:0]    state_o,
    output wire [DW-1:0] rd_data_o,
    output wire          rd_valid_o,
    input  wire          rd_ready_i
);
    // ======================================================
    // crc step, one dword per clock
    // ======================================================
    function [31:0] crc_step;
        input [31:0] c;
        input [31:0] d;
        integer      k;
        reg   [31:0] r;
        begin
            r = c;
            for (k = 31; k >= 0; k = k - 1) begin
                r = (r[31] ^ d[k]) ? ((r << 1) ^ `SLFR_CRC_POLY) : (r << 1);
            end
            crc_step = r;
        end
    endfunction

    // ======================================================
    // receive fifo
    // ======================================================
    wire       fifo_ready;
    wire [2:0] fifo_level;
    reg        push;

    slfr_fifo #(
        .WIDTH (DW),
        .DEPTH (4),
        .AW    (2)
    ) u_fifo (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .s_data_i  (rx_data_i),
        .s_valid_i (push),
        .s_ready_o (fifo_ready),
        .m_data_o  (rd_data_o),
        .m_valid_o (rd_valid_o),
        .m_ready_i (rd_ready_i),
        .level_o   (fifo_level)
    );

    // hold is raised with headroom left so in-flight dwords still fit
    wire room     = (fifo_level <= (3'd4 - HEADROOM[2:0]));
    wire fifo_emp = (fifo_level == 3'd0);

    // ======================================================
    // state machine
    // ======================================================
    reg [3:0]  st_q;
    reg [3:0]  st_d;
    reg [31:0] crc_q;
    reg [31:0] crc_d;
    reg [31:0] rxcrc_q;
    reg [31:0] rxcrc_d;
    reg        ok_d;
    reg        fail_d;
    reg        ill_d;
    reg        abt_d;
    reg        ncm_d;
    reg        cok_d;
    reg        cbad_d;

    wire rv   = rx_valid_i;
    wire prim = rx_is_prim_i;
    wire p_sync  = rv && prim && (rx_prim_i == `SLFR_P_SYNC);
    wire p_xrdy  = rv && prim && (rx_prim_i == `SLFR_P_X_RDY);
    wire p_sof   = rv && prim && (rx_prim_i == `SLFR_P_SOF);
    wire p_eof   = rv && prim && (rx_prim_i == `SLFR_P_EOF);
    wire p_wtrm  = rv && prim && (rx_prim_i == `SLFR_P_WTRM);
    wire p_rok   = rv && prim && (rx_prim_i == `SLFR_P_R_OK);
    wire p_rerr  = rv && prim && (rx_prim_i == `SLFR_P_R_ERR);
    wire p_hold  = rv && prim && (rx_prim_i == `SLFR_P_HOLD);
    wire is_data = rv && !prim;

    always @* begin
        st_d    = st_q;
        crc_d   = crc_q;
        rxcrc_d = rxcrc_q;
        push    = 1'b0;
        ok_d    = 1'b0;
        fail_d  = 1'b0;
        ill_d   = 1'b0;
        abt_d   = 1'b0;
        ncm_d   = 1'b0;
        cok_d   = 1'b0;
        cbad_d  = 1'b0;
        if (!phy_rdy_i && st_q != `SLFR_S_IDLE && st_q != `SLFR_S_NOCOMM) begin
            ncm_d = 1'b1;
            fail_d = 1'b1;
            st_d = `SLFR_S_NOCOMM;
        end else begin
            case (st_q)
                `SLFR_S_IDLE: begin
                    crc_d = `SLFR_CRC_INIT;
                    if (tp_tx_start_i && tp_tx_done_i) begin
                        st_d = `SLFR_S_SENDCRC;
                    end else if (p_xrdy) begin
                        st_d = fifo_emp ? `SLFR_S_CHKRDY : `SLFR_S_WAITFIFO;
                    end
                end
                `SLFR_S_SENDCRC: begin
                    if (p_sync) begin
                        ill_d = 1'b1;
                        fail_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end else begin
                        st_d = `SLFR_S_SENDEOF;
                    end
                end
                `SLFR_S_SENDEOF: begin
                    if (p_sync) begin
                        ill_d = 1'b1;
                        fail_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end else begin
                        st_d = `SLFR_S_WAIT;
                    end
                end
                `SLFR_S_WAIT: begin
                    if (p_rok) begin
                        ok_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end else if (p_rerr || p_sync) begin
                        fail_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end
                end
                `SLFR_S_CHKRDY: begin
                    if (p_sof) begin
                        crc_d = `SLFR_CRC_INIT;
                        st_d = `SLFR_S_RCVDATA;
                    end else if (rv && !p_xrdy) begin
                        abt_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end
                end
                `SLFR_S_WAITFIFO: begin
                    if (p_xrdy && fifo_emp) begin
                        st_d = `SLFR_S_CHKRDY;
                    end else if (rv && !p_xrdy) begin
                        abt_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end
                end
                `SLFR_S_RCVDATA, `SLFR_S_HOLD, `SLFR_S_SENDHOLD: begin
                    if (is_data) begin
                        push = 1'b1;
                        crc_d = crc_step(crc_q, rx_data_i);
                        rxcrc_d = rx_data_i;
                    end
                    if (p_sync) begin
                        abt_d = 1'b1;
                        st_d = `SLFR_S_IDLE;
                    end else if (p_eof) begin
                        st_d = `SLFR_S_RCVEOF;
                    end else if (p_wtrm && st_q == `SLFR_S_RCVDATA) begin
                        st_d = `SLFR_S_BADEND;
                    end else if (st_q == `SLFR_S_HOLD) begin
                        if (room && p_hold) begin
                            st_d = `SLFR_S_SENDHOLD;
                        end else if (room && rv) begin
                            st_d = `SLFR_S_RCVDATA;
                        end
                    end else if (!room) begin
                        st_d = `SLFR_S_HOLD;
                    end else if (p_hold) begin
                        st_d = `SLFR_S_SENDHOLD;
                    end else if (rv && st_q == `SLFR_S_SENDHOLD) begin
                        st_d = `SLFR_S_RCVDATA;
                    end
                end
                `SLFR_S_RCVEOF: begin
                    // last dword before eof carried the crc
                    if (crc_q == 32'h00000000 || rxcrc_q == 32'h00000000) begin
                        cok_d = 1'b1;
                    end else begin
                        cbad_d = 1'b1;
                    end
                    st_d = `SLFR_S_IDLE;
                end
                `SLFR_S_BADEND: begin
                    if (p_sync) begin
                        st_d = `SLFR_S_IDLE;
                    end
                end
                `SLFR_S_NOCOMM: begin
                    if (phy_rdy_i) begin
                        st_d = `SLFR_S_IDLE;
                    end
                end
                default: begin
                    st_d = `SLFR_S_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // transmit word selection
    // ======================================================
    // pending control frame drops a receive back to idle
    wire [3:0] st_n = (tp_ctrl_pend_i && st_d != `SLFR_S_NOCOMM) ?
                      `SLFR_S_IDLE : st_d;
    reg [3:0] txp_d;
    always @* begin
        case (st_n)
            `SLFR_S_SENDCRC:  txp_d = `SLFR_P_CRC;
            `SLFR_S_SENDEOF:  txp_d = `SLFR_P_EOF;
            `SLFR_S_WAIT:     txp_d = `SLFR_P_WTRM;
            `SLFR_S_CHKRDY:   txp_d = `SLFR_P_R_RDY;
            `SLFR_S_WAITFIFO: txp_d = `SLFR_P_SYNC;
            `SLFR_S_RCVDATA:  txp_d = tp_dmat_req_i ? `SLFR_P_DMAT : `SLFR_P_R_IP;
            `SLFR_S_HOLD:     txp_d = `SLFR_P_HOLD;
            `SLFR_S_SENDHOLD: txp_d = tp_dmat_req_i ? `SLFR_P_DMAT : `SLFR_P_HOLDA;
            `SLFR_S_RCVEOF:   txp_d = `SLFR_P_R_IP;
            `SLFR_S_BADEND:   txp_d = `SLFR_P_R_ERR;
            default:          txp_d = `SLFR_P_SYNC;
        endcase
    end

    // ======================================================
    // registers
    // ======================================================
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q          <= `SLFR_S_IDLE;
            crc_q         <= `SLFR_CRC_INIT;
            rxcrc_q       <= 32'h00000000;
            tx_is_prim_o  <= 1'b1;
            tx_prim_o     <= `SLFR_P_SYNC;
            tx_data_o     <= {DW{1'b0}};
            tp_tx_ok_o    <= 1'b0;
            tp_tx_fail_o  <= 1'b0;
            tp_illegal_o  <= 1'b0;
            tp_rx_abort_o <= 1'b0;
            tp_nocomm_o   <= 1'b0;
            tp_crc_ok_o   <= 1'b0;
            tp_crc_bad_o  <= 1'b0;
            state_o       <= `SLFR_S_IDLE;
        end else begin
            st_q          <= st_n;
            crc_q         <= crc_d;
            rxcrc_q       <= rxcrc_d;
            tx_is_prim_o  <= (txp_d != `SLFR_P_CRC);
            tx_prim_o     <= txp_d;
            tx_data_o     <= (txp_d == `SLFR_P_CRC) ? crc_q : {DW{1'b0}};
            tp_tx_ok_o    <= ok_d;
            tp_tx_fail_o  <= fail_d;
            tp_illegal_o  <= ill_d;
            tp_rx_abort_o <= abt_d;
            tp_nocomm_o   <= ncm_d;
            tp_crc_ok_o   <= cok_d;
            tp_crc_bad_o  <= cbad_d;
            state_o       <= st_n;
        end
    end
endmodule

`default_nettype wire

// ### testbench/slfr_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "slfr_defines.vh"
// ==========================================================
// link checker
// ==========================================================
module slfr_link_checker (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       phy_rdy_i,
    input wire logic       rx_is_prim_i,
    input wire logic [3:0] rx_prim_i,
    input wire logic       rx_valid_i,
    input wire logic       tx_is_prim_o,
    input wire logic [3:0] tx_prim_o,
    input wire logic       tp_tx_start_i,
    input wire logic       tp_tx_done_i,
    input wire logic       tp_dmat_req_i,
    input wire logic       tp_ctrl_pend_i,
    input wire logic       tp_tx_ok_o,
    input wire logic       tp_tx_fail_o,
    input wire logic       tp_illegal_o,
    input wire logic       tp_rx_abort_o,
    input wire logic       tp_nocomm_o,
    input wire logic [3:0] state_o
);
    // primitive arriving this cycle, none for data or silence
    wire logic [3:0] pr = (rx_valid_i && rx_is_prim_i) ? rx_prim_i : `SLFR_P_NONE;
    wire logic       go = phy_rdy_i && !tp_ctrl_pend_i;
    wire logic [3:0] s  = state_o;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_start;
        s == `SLFR_S_IDLE && tp_tx_start_i && tp_tx_done_i && go && !rx_valid_i;
    endsequence
    sequence s_calm2;
        (go && pr != `SLFR_P_SYNC) [*2];
    endsequence
    chk_close_order: assert property (s_start ##1 s_calm2 |=> s == `SLFR_S_WAIT)
        else $error("frame close did not reach wait");
    chk_crc_dword: assert property (s == `SLFR_S_SENDCRC |-> !tx_is_prim_o)
        else $error("crc state not sending crc dword");
    chk_close_sync: assert property ((s == `SLFR_S_SENDCRC || s == `SLFR_S_SENDEOF) && go
        && pr == `SLFR_P_SYNC |=> tp_illegal_o && tp_tx_fail_o && s == `SLFR_S_IDLE)
        else $error("sync during close not failed");
    chk_wait_stay: assert property (s == `SLFR_S_WAIT && go && !(pr inside {`SLFR_P_R_OK,
        `SLFR_P_R_ERR, `SLFR_P_SYNC}) |=> s == `SLFR_S_WAIT && tx_prim_o == `SLFR_P_WTRM)
        else $error("wait state left or not sending wtrm");
    chk_result_ok: assert property (s == `SLFR_S_WAIT && go && pr == `SLFR_P_R_OK
        |=> tp_tx_ok_o && !tp_tx_fail_o && s == `SLFR_S_IDLE)
        else $error("r_ok not reported as success");
    chk_result_bad: assert property (s == `SLFR_S_WAIT && go && (pr == `SLFR_P_R_ERR
        || pr == `SLFR_P_SYNC) |=> tp_tx_fail_o && !tp_tx_ok_o && s == `SLFR_S_IDLE)
        else $error("r_err or sync not reported as failure");
    chk_phy_lost: assert property (!phy_rdy_i && !tp_ctrl_pend_i && s != `SLFR_S_IDLE
        && s != `SLFR_S_NOCOMM |=> tp_nocomm_o && tp_tx_fail_o && s == `SLFR_S_NOCOMM)
        else $error("phy loss not reported");
    chk_ready_wait: assert property (s == `SLFR_S_CHKRDY && go && pr == `SLFR_P_X_RDY
        |=> s == `SLFR_S_CHKRDY && tx_prim_o == `SLFR_P_R_RDY)
        else $error("ready state not held on x_rdy");
    chk_ready_sof: assert property (s == `SLFR_S_CHKRDY && go && pr == `SLFR_P_SOF
        |=> s == `SLFR_S_RCVDATA)
        else $error("sof did not start reception");
    chk_fifo_sync: assert property (s == `SLFR_S_WAITFIFO |-> tx_prim_o == `SLFR_P_SYNC)
        else $error("fifo wait not sending sync");
    chk_rcv_ip: assert property (s == `SLFR_S_RCVDATA && !tp_dmat_req_i && !$past(tp_dmat_req_i)
        |-> tx_prim_o == `SLFR_P_R_IP)
        else $error("receive not sending r_ip");
    chk_rcv_abort: assert property (s == `SLFR_S_RCVDATA && go && pr == `SLFR_P_SYNC
        |=> tp_rx_abort_o && s == `SLFR_S_IDLE)
        else $error("sync in receive not aborted");
    chk_hold_sends: assert property (s == `SLFR_S_HOLD |-> tx_prim_o == `SLFR_P_HOLD)
        else $error("hold state not sending hold");
    chk_ctrl_idle: assert property (tp_ctrl_pend_i && phy_rdy_i && s != `SLFR_S_NOCOMM
        && s != `SLFR_S_IDLE |=> s == `SLFR_S_IDLE)
        else $error("pending control frame did not force idle");
endmodule

bind slfr_link slfr_link_checker u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .phy_rdy_i(phy_rdy_i),
    .rx_is_prim_i(rx_is_prim_i), .rx_prim_i(rx_prim_i), .rx_valid_i(rx_valid_i),
    .tx_is_prim_o(tx_is_prim_o), .tx_prim_o(tx_prim_o), .tp_tx_start_i(tp_tx_start_i),
    .tp_tx_done_i(tp_tx_done_i), .tp_dmat_req_i(tp_dmat_req_i), .tp_ctrl_pend_i(tp_ctrl_pend_i),
    .tp_tx_ok_o(tp_tx_ok_o), .tp_tx_fail_o(tp_tx_fail_o), .tp_illegal_o(tp_illegal_o),
    .tp_rx_abort_o(tp_rx_abort_o), .tp_nocomm_o(tp_nocomm_o), .state_o(state_o));
`default_nettype wire

// ### testbench/slfr_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// peer link model, one dword per put
// ==========================================================
module slfr_peer (
    input  wire logic   mclk_i,
    output logic        rx_valid_o,
    output logic        rx_is_prim_o,
    output logic [3:0]  rx_prim_o,
    output logic [31:0] rx_data_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_is_prim_o = 1'b0;
        rx_prim_o = 4'h0;
        rx_data_o = 32'h0;
    end
    task automatic put(input logic ip, input logic [3:0] p, input logic [31:0] d);
        @(posedge mclk_i);
        rx_valid_o <= 1'b1;
        rx_is_prim_o <= ip;
        rx_prim_o <= p;
        rx_data_o <= d;
    endtask
    // silent lines are inverted so a stale word can never pass for a fresh one
    task automatic quiet();
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_is_prim_o <= ~rx_is_prim_o;
        rx_prim_o <= ~rx_prim_o;
        rx_data_o <= ~rx_data_o;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "slfr_defines.vh"
// ==========================================================
// bench
// ==========================================================
module tb;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        phy_rdy_i = 1'b1;
    logic        tp_tx_start_i = 1'b0;
    logic        tp_tx_done_i = 1'b0;
    logic        tp_dmat_req_i = 1'b0;
    logic        tp_ctrl_pend_i = 1'b0;
    logic        rd_ready_i = 1'b0;
    wire logic   rx_valid_i, rx_is_prim_i, tx_is_prim_o, rd_valid_o;
    wire logic   tp_tx_ok_o, tp_tx_fail_o, tp_illegal_o, tp_rx_abort_o, tp_nocomm_o;
    wire logic [3:0]  rx_prim_i, tx_prim_o, state_o;
    wire logic [31:0] rx_data_i, rd_data_o;
    logic [31:0] exq [$];
    logic [3:0]  tab [3] = '{`SLFR_P_R_OK, `SLFR_P_R_ERR, `SLFR_P_SYNC};
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    initial forever #50 mclk_i = ~mclk_i;

    slfr_link #(.DW(32), .HEADROOM(2)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .phy_rdy_i(phy_rdy_i), .rx_is_prim_i(rx_is_prim_i), .rx_prim_i(rx_prim_i),
        .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .tx_is_prim_o(tx_is_prim_o),
        .tx_prim_o(tx_prim_o), .tx_data_o(), .tp_tx_start_i(tp_tx_start_i),
        .tp_tx_done_i(tp_tx_done_i), .tp_dmat_req_i(tp_dmat_req_i),
        .tp_ctrl_pend_i(tp_ctrl_pend_i), .tp_tx_ok_o(tp_tx_ok_o), .tp_tx_fail_o(tp_tx_fail_o),
        .tp_illegal_o(tp_illegal_o), .tp_rx_abort_o(tp_rx_abort_o), .tp_nocomm_o(tp_nocomm_o),
        .tp_crc_ok_o(), .tp_crc_bad_o(), .state_o(state_o), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i));
    slfr_peer u_peer (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i), .rx_is_prim_o(rx_is_prim_i),
        .rx_prim_o(rx_prim_i), .rx_data_o(rx_data_i));

    task automatic tally_and_finish();
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic snd(input logic [3:0] p);
        u_peer.put(1'b1, p, 32'h0);
    endtask
    // the model queue holds every word the link must pass on, in order
    task automatic dat();
        logic [31:0] w;
        w = $urandom;
        exq.push_back(w);
        u_peer.put(1'b0, `SLFR_P_NONE, w);
    endtask
    task automatic wait_st(input logic [3:0] e);
        for (int n = 0; n < 12 && state_o !== e; n++) @(negedge mclk_i);
        chk("state", state_o, e);
    endtask
    task automatic close_begin(input logic [3:0] p);
        @(posedge mclk_i);
        tp_tx_start_i <= 1'b1;
        tp_tx_done_i <= 1'b1;
        snd(p);
        tp_tx_start_i <= 1'b0;
        tp_tx_done_i <= 1'b0;
        @(negedge mclk_i);
        chk("crc_state", state_o, `SLFR_S_SENDCRC);
        chk("crc_dword", tx_is_prim_o, 0);
    endtask

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fail_count++;
            tally_and_finish();
        end
        if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
            chk("rd_data", rd_data_o, exq.size() ? exq.pop_front() : 32'hx);
    end

    initial begin
        void'($urandom(32'he9038614));
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(negedge mclk_i);
        chk("tx_prim", tx_prim_o, `SLFR_P_SYNC);
        foreach (tab[i]) begin
            close_begin(`SLFR_P_R_IP);
            u_peer.quiet();
            @(negedge mclk_i);
            chk("tx_prim", tx_prim_o, `SLFR_P_EOF);
            @(negedge mclk_i);
            chk("tx_prim", tx_prim_o, `SLFR_P_WTRM);
            repeat ($urandom_range(4, 1)) snd(`SLFR_P_R_IP);
            snd(tab[i]);
            @(negedge mclk_i);
            chk("state", state_o, `SLFR_S_WAIT);
            u_peer.quiet();
            @(negedge mclk_i);
            chk("tx_ok", tp_tx_ok_o, i == 0);
            chk("tx_fail", tp_tx_fail_o, i != 0);
            chk("state", state_o, `SLFR_S_IDLE);
        end
        for (int i = 0; i < 2; i++) begin
            close_begin(i ? `SLFR_P_R_IP : `SLFR_P_SYNC);
            if (i) snd(`SLFR_P_SYNC);
            u_peer.quiet();
            @(negedge mclk_i);
            chk("illegal", tp_illegal_o, 1);
            chk("state", state_o, `SLFR_S_IDLE);
        end
        close_begin(`SLFR_P_R_IP);
        u_peer.quiet();
        @(posedge mclk_i);
        phy_rdy_i <= 1'b0;
        repeat (2) @(negedge mclk_i);
        chk("nocomm", tp_nocomm_o, 1);
        chk("state", state_o, `SLFR_S_NOCOMM);
        @(posedge mclk_i);
        phy_rdy_i <= 1'b1;
        wait_st(`SLFR_S_IDLE);
        // receive with back-pressure: reader stalls until the link holds
        snd(`SLFR_P_X_RDY);
        snd(`SLFR_P_X_RDY);
        @(negedge mclk_i);
        chk("tx_prim", tx_prim_o, `SLFR_P_R_RDY);
        snd(`SLFR_P_SOF);
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_CHKRDY);
        repeat (3) dat();
        u_peer.quiet();
        wait_st(`SLFR_S_HOLD);
        chk("tx_prim", tx_prim_o, `SLFR_P_HOLD);
        dat();
        u_peer.quiet();
        rd_ready_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        dat();
        u_peer.quiet();
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_RCVDATA);
        snd(`SLFR_P_HOLD);
        tp_dmat_req_i <= 1'b1;
        u_peer.quiet();
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_SENDHOLD);
        chk("tx_prim", tx_prim_o, `SLFR_P_DMAT);
        dat();
        snd(`SLFR_P_EOF);
        @(negedge mclk_i);
        chk("tx_prim", tx_prim_o, `SLFR_P_DMAT);
        tp_dmat_req_i <= 1'b0;
        u_peer.quiet();
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_RCVEOF);
        wait_st(`SLFR_S_IDLE);
        snd(`SLFR_P_X_RDY);
        snd(`SLFR_P_SOF);
        dat();
        // keep this word queued so the next x_rdy finds the fifo busy
        rd_ready_i <= 1'b0;
        snd(`SLFR_P_EOF);
        u_peer.quiet();
        wait_st(`SLFR_S_IDLE);
        snd(`SLFR_P_X_RDY);
        snd(`SLFR_P_X_RDY);
        @(negedge mclk_i);
        chk("tx_prim", tx_prim_o, `SLFR_P_SYNC);
        u_peer.quiet();
        rd_ready_i <= 1'b1;
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_WAITFIFO);
        repeat (3) @(posedge mclk_i);
        snd(`SLFR_P_X_RDY);
        snd(`SLFR_P_R_IP);
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_CHKRDY);
        u_peer.quiet();
        @(negedge mclk_i);
        chk("state", state_o, `SLFR_S_IDLE);
        for (int i = 0; i < 3; i++) begin
            snd(`SLFR_P_X_RDY);
            snd(`SLFR_P_SOF);
            dat();
            if (i < 2) snd(i ? `SLFR_P_WTRM : `SLFR_P_SYNC);
            else u_peer.quiet();
            tp_ctrl_pend_i <= (i == 2);
            u_peer.quiet();
            tp_ctrl_pend_i <= 1'b0;
            @(negedge mclk_i);
            chk("rx_abort", tp_rx_abort_o, i == 0);
            chk("state", state_o, i == 1 ? `SLFR_S_BADEND : `SLFR_S_IDLE);
            if (i == 1) snd(`SLFR_P_SYNC);
            u_peer.quiet();
            wait_st(`SLFR_S_IDLE);
        end
        repeat (4) @(negedge mclk_i);
        chk("rd_left", exq.size(), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
